//--- rtl/ncur_pkg.sv
package ncur_pkg;

  // Opcodes this controller may issue; nothing outside this set reaches the pins
  localparam logic [7:0] OP_READ1  = 8'h00;
  localparam logic [7:0] OP_READ2  = 8'h30;
  localparam logic [7:0] OP_PROG1  = 8'h80;
  localparam logic [7:0] OP_PROG2  = 8'h10;
  localparam logic [7:0] OP_ERASE1 = 8'h60;
  localparam logic [7:0] OP_ERASE2 = 8'hd0;
  localparam logic [7:0] OP_STATUS = 8'h70;
  localparam logic [7:0] OP_RESET  = 8'hff;

  // Status byte fields
  localparam int ST_FAIL_BIT    = 0;
  localparam int ST_REWRITE_BIT = 3;
  localparam int ST_WP_BIT      = 7;

  // Geometry
  localparam logic [12:0] SECT_BYTES    = 13'h0210;
  localparam logic [3:0]  SECT_PER_PAGE = 4'h8;
  localparam logic [2:0]  MAX_PARTIAL   = 3'h4;
  localparam int          BLOCKS        = 2048;
  localparam logic [10:0] LAST_BLOCK    = 11'h7ff;
  localparam logic [12:0] BB_COL        = 13'h1000;
  localparam logic [7:0]  BAD_MARK      = 8'h00;
  localparam logic [2:0]  ERASE_ASTART  = 3'h2;
  localparam logic [2:0]  LAST_ADDR     = 3'h4;

  // Timing
  localparam int         CLK_NS   = 40;
  localparam int         T_WB_NS  = 100;
  localparam logic [1:0] WB_CYC   = 2'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] RD_LOW   = 3'h1;
  localparam logic [2:0] RD_TAKE  = 3'h4;

  typedef enum logic [2:0] {
    NCUR_RESET  = 3'h0,
    NCUR_STATUS = 3'h1,
    NCUR_READ   = 3'h2,
    NCUR_PROG   = 3'h3,
    NCUR_ERASE  = 3'h4,
    NCUR_CHECK  = 3'h5
  } ncur_op_type;

  typedef enum logic [12:0] {
    S_INIT   = 13'h0001,
    S_IDLE   = 13'h0002,
    S_CMD    = 13'h0004,
    S_ADDR   = 13'h0008,
    S_WDATA  = 13'h0010,
    S_CMD2   = 13'h0020,
    S_WAITB  = 13'h0040,
    S_BUSY   = 13'h0080,
    S_STAT   = 13'h0100,
    S_STATRD = 13'h0200,
    S_RESUME = 13'h0400,
    S_RDATA  = 13'h0800,
    S_FIN    = 13'h1000
  } ncur_state_type;

endpackage

//--- rtl/ncur_host.sv
// Rules of the document this block works with
// R1 - During power-on busy, only reset or status read may be issued.
// R2 - Never issue a command code outside the defined set.
// R3 - While busy, issue only status read, second status read or reset.
// R4 - After serial data input, only column change, program or reset follow.
// R5 - Device drops a pending program if another command follows data input.
// R6 - Program pages of a block in strictly ascending order.
// R7 - Status read in read mode holds status output until read command.
// R8 - Read command after status resumes data at the stopped column.
// R9 - Write protect low aborts and blocks program and erase.
// R10 - Device ignores the value of a sixth address cycle.
// R11 - Partial programs write whole 528-byte sectors, main and spare together.
// R12 - At most four partial programs on one page between erases.
// R13 - Block is bad when its checked column reads zero.
// R14 - Bad-block check ignores the ECC pass or fail status.
// R15 - Never erase a block known to be bad.
// R16 - Allow 2008 to 2048 good blocks and keep bad ones unused.
// R17 - On program failure exclude the block; user rewrites elsewhere.
// R18 - Device corrects eight bits per sector and flags nine as uncorrectable.
// R19 - Report the rewrite-recommended status after reads.
// R20 - Mark blocks bad only on program or erase status failure. Code also marks a block bad on a zero bad-block check mark.
// R21 - Reset command stops any operation and returns device to idle.
// R22 - After status command each read strobe returns the status byte.
// R23 - Status bit one is pass zero, fail one.
// R24 - Status bit eight is one when not write protected.
// R25 - Reset while ready pulses busy briefly, data untouched.
// R26 - Back-to-back resets each complete a full reset period.
`timescale 1ns/1ps
module ncur_host (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic                  cmd_valid,
  input  wire ncur_pkg::ncur_op_type cmd_op,
  input  wire logic [10:0]           cmd_block,
  input  wire logic [5:0]            cmd_page,
  input  wire logic [2:0]            cmd_sector,
  input  wire logic [3:0]            cmd_nsect,
  input  wire logic                  protect,
  input  wire logic [7:0]            wr_data,
  input  wire logic                  wr_valid,
  input  wire logic [7:0]            io_in,
  input  wire logic                  ready_busy_output,
  output logic                       cmd_ready,
  output logic                       wr_ready,
  output logic [7:0]                 rd_data,
  output logic                       rd_valid,
  output logic                       done,
  output logic                       refused,
  output logic [7:0]                 done_status,
  output logic                       rewrite_hint,
  output logic                       block_bad,
  output logic                       init_done,
  output logic                       ce_n,
  output logic                       cle,
  output logic                       ale,
  output logic                       we_n,
  output logic                       output_strobe_n,
  output logic                       wp_n,
  output logic [7:0]                 io_out,
  output logic                       io_oe
);

  localparam int            BLOCKS_W = 11;

  ncur_pkg::ncur_state_type state;
  ncur_pkg::ncur_op_type    op;
  logic [1:0]               io_m1 [8];
  logic [7:0]               io_s;
  logic                     rb_m;
  logic                     rb_s;
  logic [BLOCKS_W-1:0]      blk;
  logic [5:0]               page;
  logic [12:0]              col;
  logic [12:0]              nbytes;
  logic [12:0]              bcnt;
  logic [2:0]               aidx;
  logic [2:0]               ph;
  logic [1:0]               wcnt;
  logic                     have;
  logic [10:0]              sweep;
  logic [7:0]               last_byte;
  logic                     bad_tab [ncur_pkg::BLOCKS];
  logic [6:0]               hi_page [ncur_pkg::BLOCKS];
  logic [2:0]               pcnt    [ncur_pkg::BLOCKS];

  // Address byte for cycle idx; row is block then page
  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [12:0] c,
                                           input logic [16:0] r);
    logic [7:0] b;
    b = 8'h00;
    if (idx == 3'h0) begin
      b = c[7:0];
    end else if (idx == 3'h1) begin
      b = {3'h0, c[12:8]};
    end else if (idx == 3'h2) begin
      b = r[7:0];
    end else if (idx == 3'h3) begin
      b = r[15:8];
    end else begin
      b = {7'h00, r[16]};
    end
    return b;
  endfunction

  wire [16:0] row        = {blk, page};
  wire [6:0]  pg1        = {1'b0, cmd_page} + 7'h01;
  wire [6:0]  hp         = hi_page[cmd_block];
  wire [2:0]  pc         = pcnt[cmd_block];
  wire        is_bad     = bad_tab[cmd_block];
  wire [4:0]  sect_end   = {2'h0, cmd_sector} + {1'b0, cmd_nsect};
  // R11 whole sectors
  wire        sect_ok    = (cmd_nsect != 4'h0) && (sect_end <= {1'b0, ncur_pkg::SECT_PER_PAGE});
  // R6 ascending pages
  wire        order_ok   = (pg1 > hp) || ((pg1 == hp) && (pc < ncur_pkg::MAX_PARTIAL));
  // R15 no bad erase
  wire        use_ok     = !is_bad;
  wire        prog_ok    = sect_ok && order_ok && use_ok;
  // R16 bad blocks kept out
  wire        read_ok    = sect_ok && use_ok;
  wire        req_bad    = ((cmd_op == ncur_pkg::NCUR_PROG) && !prog_ok) ||
                           ((cmd_op == ncur_pkg::NCUR_READ) && !read_ok) ||
                           ((cmd_op == ncur_pkg::NCUR_ERASE) && !use_ok) ||
                           (cmd_op > ncur_pkg::NCUR_CHECK);
  wire        take       = cmd_valid && cmd_ready;
  wire [12:0] sect_col   = 13'(cmd_sector * ncur_pkg::SECT_BYTES);
  wire [12:0] sect_len   = 13'(cmd_nsect * ncur_pkg::SECT_BYTES);
  // R2 fixed opcode set
  wire [7:0]  first_cmd  = (op == ncur_pkg::NCUR_RESET)  ? ncur_pkg::OP_RESET :
                           (op == ncur_pkg::NCUR_STATUS) ? ncur_pkg::OP_STATUS :
                           (op == ncur_pkg::NCUR_PROG)   ? ncur_pkg::OP_PROG1 :
                           (op == ncur_pkg::NCUR_ERASE)  ? ncur_pkg::OP_ERASE1 : ncur_pkg::OP_READ1;
  // R4 program closes only with its own confirm
  wire [7:0]  second_cmd = (op == ncur_pkg::NCUR_PROG)  ? ncur_pkg::OP_PROG2 :
                           (op == ncur_pkg::NCUR_ERASE) ? ncur_pkg::OP_ERASE2 : ncur_pkg::OP_READ2;
  wire [7:0]  wr_byte    = (state == ncur_pkg::S_CMD)    ? first_cmd :
                           (state == ncur_pkg::S_ADDR)   ? addr_byte(aidx, col, row) :
                           (state == ncur_pkg::S_CMD2)   ? second_cmd :
                           (state == ncur_pkg::S_STAT)   ? ncur_pkg::OP_STATUS :
                           (state == ncur_pkg::S_RESUME) ? ncur_pkg::OP_READ1 : io_out;
  wire        strobing   = (state == ncur_pkg::S_CMD) || (state == ncur_pkg::S_ADDR) ||
                           (state == ncur_pkg::S_CMD2) || (state == ncur_pkg::S_STAT) ||
                           (state == ncur_pkg::S_RESUME) || ((state == ncur_pkg::S_WDATA) && have);
  wire        strobe_end = strobing && (ph != 3'h0);
  wire        rd_take    = ph == ncur_pkg::RD_TAKE;
  wire        is_rdop    = (op == ncur_pkg::NCUR_READ) || (op == ncur_pkg::NCUR_CHECK);
  wire        last_data  = (bcnt + 13'h0001) == nbytes;

  // Pins are asynchronous to ref_clk
  genvar gi;
  for (gi = 0; gi < 8; gi++) begin : g_io_sync
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        io_m1[gi] <= 2'h0;
      end else if (clk_en) begin
        io_m1[gi] <= {io_m1[gi][0], io_in[gi]};
      end
    end
    assign io_s[gi] = io_m1[gi][1];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rb_m <= 1'b0;
      rb_s <= 1'b0;
    end else if (clk_en) begin
      rb_m <= ready_busy_output;
      rb_s <= rb_m;
    end
  end

  // Tables have no reset; cleared by the sweep in S_INIT
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (state == ncur_pkg::S_INIT) begin
        bad_tab[sweep] <= 1'b0;
        hi_page[sweep] <= 7'h00;
        pcnt[sweep]    <= 3'h0;
      end else if (take && !req_bad && (cmd_op == ncur_pkg::NCUR_PROG)) begin
        // R12 partial count
        hi_page[cmd_block] <= pg1;
        pcnt[cmd_block]    <= (pg1 > hp) ? 3'h1 : pc + 3'h1;
      end else if (take && !req_bad && (cmd_op == ncur_pkg::NCUR_ERASE)) begin
        hi_page[cmd_block] <= 7'h00;
        pcnt[cmd_block]    <= 3'h0;
      // Refused requests carry a stale status byte
      end else if ((state == ncur_pkg::S_FIN) && !refused) begin
        // R13 zero mark means bad
        if ((op == ncur_pkg::NCUR_CHECK) && (last_byte == ncur_pkg::BAD_MARK)) begin
          bad_tab[blk] <= 1'b1;
        // R20 program or erase status failure marks
        end else if (((op == ncur_pkg::NCUR_PROG) || (op == ncur_pkg::NCUR_ERASE)) &&
                     done_status[ncur_pkg::ST_FAIL_BIT]) begin
          bad_tab[blk] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ncur_pkg::S_INIT;
      op <= ncur_pkg::NCUR_RESET;
      {blk, page, col, nbytes, bcnt, aidx, ph, wcnt, have, sweep} <= '0;
      {cmd_ready, wr_ready, rd_valid, done, refused, rewrite_hint, block_bad, init_done} <= '0;
      {rd_data, done_status, last_byte, io_out} <= '0;
      {cle, ale, io_oe} <= 3'h0;
      {ce_n, we_n, output_strobe_n, wp_n} <= 4'hf;
    end else if (clk_en) begin
      // R9 protect while requested
      wp_n <= !protect;
      rd_valid <= 1'b0;
      done <= 1'b0;
      if (strobing && (ph == 3'h0)) begin
        we_n <= 1'b0;
        io_oe <= 1'b1;
        io_out <= wr_byte;
        cle <= (state != ncur_pkg::S_ADDR) && (state != ncur_pkg::S_WDATA);
        ale <= state == ncur_pkg::S_ADDR;
        ph <= 3'h1;
      end else if (strobe_end) begin
        we_n <= 1'b1;
        ph <= 3'h0;
      end
      case (state)
        ncur_pkg::S_INIT: begin
          sweep <= sweep + 11'h001;
          // R1 nothing until power-on busy ends
          if ((sweep == ncur_pkg::LAST_BLOCK) && rb_s) begin
            init_done <= 1'b1;
            ce_n <= 1'b0;
            cmd_ready <= 1'b1;
            state <= ncur_pkg::S_IDLE;
          end
        end
        ncur_pkg::S_IDLE: begin
          io_oe <= 1'b0;
          if (take) begin
            cmd_ready <= 1'b0;
            op <= cmd_op;
            blk <= cmd_block;
            page <= cmd_page;
            col <= (cmd_op == ncur_pkg::NCUR_CHECK) ? ncur_pkg::BB_COL : sect_col;
            nbytes <= (cmd_op == ncur_pkg::NCUR_CHECK) ? 13'h0001 : sect_len;
            aidx <= (cmd_op == ncur_pkg::NCUR_ERASE) ? ncur_pkg::ERASE_ASTART : 3'h0;
            bcnt <= 13'h0000;
            block_bad <= is_bad;
            refused <= req_bad;
            rewrite_hint <= 1'b0;
            state <= req_bad ? ncur_pkg::S_FIN : ncur_pkg::S_CMD;
          end
        end
        ncur_pkg::S_CMD: begin
          if (strobe_end) begin
            state <= (op == ncur_pkg::NCUR_RESET)  ? ncur_pkg::S_WAITB :
                     (op == ncur_pkg::NCUR_STATUS) ? ncur_pkg::S_STATRD : ncur_pkg::S_ADDR;
          end
        end
        ncur_pkg::S_ADDR: begin
          if (strobe_end) begin
            aidx <= aidx + 3'h1;
            if (aidx == ncur_pkg::LAST_ADDR) begin
              state <= (op == ncur_pkg::NCUR_PROG) ? ncur_pkg::S_WDATA : ncur_pkg::S_CMD2;
            end
          end
        end
        ncur_pkg::S_WDATA: begin
          if (!have) begin
            wr_ready <= !(wr_valid && wr_ready);
            if (wr_valid && wr_ready) begin
              io_out <= wr_data;
              have <= 1'b1;
            end
          end else if (strobe_end) begin
            have <= 1'b0;
            bcnt <= bcnt + 13'h0001;
            if (last_data) begin
              state <= ncur_pkg::S_CMD2;
            end
          end
        end
        ncur_pkg::S_CMD2: begin
          if (strobe_end) begin
            wcnt <= 2'h0;
            state <= ncur_pkg::S_WAITB;
          end
        end
        ncur_pkg::S_WAITB: begin
          // R26 wait for busy to rise before polling
          io_oe <= 1'b0;
          wcnt <= wcnt + 2'h1;
          if (wcnt == ncur_pkg::WB_CYC) begin
            state <= ncur_pkg::S_BUSY;
          end
        end
        ncur_pkg::S_BUSY: begin
          // R3 no command while busy
          if (rb_s) begin
            state <= (op == ncur_pkg::NCUR_RESET) ? ncur_pkg::S_FIN : ncur_pkg::S_STAT;
          end
        end
        ncur_pkg::S_STAT: begin
          if (strobe_end) begin
            state <= ncur_pkg::S_STATRD;
          end
        end
        ncur_pkg::S_STATRD, ncur_pkg::S_RDATA: begin
          io_oe <= 1'b0;
          ph <= rd_take ? 3'h0 : ph + 3'h1;
          if (ph == ncur_pkg::RD_LOW) begin
            output_strobe_n <= 1'b0;
          end
          if (rd_take) begin
            output_strobe_n <= 1'b1;
            if (state == ncur_pkg::S_STATRD) begin
              // R22 status on strobe
              done_status <= io_s;
              // R19 rewrite hint
              rewrite_hint <= is_rdop && io_s[ncur_pkg::ST_REWRITE_BIT];
              // R7 leave status mode by read command
              state <= is_rdop ? ncur_pkg::S_RESUME : ncur_pkg::S_FIN;
            end else begin
              // R14 byte judged, status ignored
              rd_data <= io_s;
              rd_valid <= 1'b1;
              last_byte <= io_s;
              bcnt <= bcnt + 13'h0001;
              if (last_data) begin
                state <= ncur_pkg::S_FIN;
              end
            end
          end
        end
        ncur_pkg::S_RESUME: begin
          // R8 no new address after resume
          if (strobe_end) begin
            state <= ncur_pkg::S_RDATA;
          end
        end
        ncur_pkg::S_FIN: begin
          // R17 failed block leaves service
          block_bad <= block_bad || refused ||
                       ((op == ncur_pkg::NCUR_CHECK) && (last_byte == ncur_pkg::BAD_MARK)) ||
                       (((op == ncur_pkg::NCUR_PROG) || (op == ncur_pkg::NCUR_ERASE)) &&
                        done_status[ncur_pkg::ST_FAIL_BIT]);
          done <= 1'b1;
          cmd_ready <= 1'b1;
          state <= ncur_pkg::S_IDLE;
        end
        default: begin
          state <= ncur_pkg::S_IDLE;
        end
      endcase
    end
  end

endmodule // ncur_host

//--- dv/ncur_host_monitor.sv
`timescale 1ns/1ps
module ncur_host_monitor (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  cmd_valid,
  input wire ncur_pkg::ncur_op_type cmd_op,
  input wire logic                  cmd_ready,
  input wire logic                  done,
  input wire logic                  refused,
  input wire logic [7:0]            done_status,
  input wire logic                  rewrite_hint,
  input wire logic                  block_bad,
  input wire logic                  init_done,
  input wire logic                  ce_n,
  input wire logic                  cle,
  input wire logic                  we_n,
  input wire logic                  output_strobe_n,
  input wire logic [7:0]            io_out,
  input wire logic                  io_oe,
  input wire logic                  ready_busy_output
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire                   cmd_cyc = !ce_n && cle && !we_n;
  wire                   take = cmd_valid && cmd_ready;
  logic                  in_prog;
  ncur_pkg::ncur_op_type op_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_prog <= 1'b0;
      op_q <= ncur_pkg::NCUR_RESET;
    end else begin
      if (cmd_cyc) in_prog <= io_out == 8'h80;
      if (take) op_q <= cmd_op;
    end
  end
  a_init_quiet: assert property (!init_done |-> we_n && output_strobe_n)
    else $error("strobe before init");
  a_init_ready: assert property ($rose(init_done) |-> $past(ready_busy_output))
    else $error("init ended while busy");
  a_cmd_set: assert property (cmd_cyc |-> io_out inside {8'h00, 8'h30, 8'h80, 8'h10, 8'h60, 8'hd0, 8'h70, 8'hff})
    else $error("unknown command code");
  a_busy_cmds: assert property (cmd_cyc && !ready_busy_output |-> io_out inside {8'h70, 8'h71, 8'hff})
    else $error("command while busy");
  a_prog_follow: assert property (cmd_cyc && in_prog |-> io_out inside {8'h85, 8'h10, 8'h11, 8'hff})
    else $error("bad command after data input");
  a_refuse_quiet: assert property (take && cmd_op > ncur_pkg::NCUR_CHECK |=> we_n [*3])
    else $error("pins moved on refused op");
  a_refuse_done: assert property (take && cmd_op > ncur_pkg::NCUR_CHECK |-> ##[2:3] (done && refused))
    else $error("refusal not reported");
  a_fail_marks: assert property (done && !refused && op_q == ncur_pkg::NCUR_PROG && done_status[0] |-> block_bad)
    else $error("failed block not marked");
  a_bad_cause: assert property (done && block_bad && !refused && op_q != ncur_pkg::NCUR_CHECK |-> done_status[0])
    else $error("block marked without fail");
  a_hint_read: assert property (done && op_q == ncur_pkg::NCUR_PROG |-> !rewrite_hint)
    else $error("rewrite hint on program");
  a_bus_turn: assert property (!output_strobe_n |-> !io_oe && we_n)
    else $error("bus contention on read");
endmodule // ncur_host_monitor
bind ncur_host ncur_host_monitor u_mon (.*);

//--- dv/ncur_nand_model.sv
`timescale 1ns/1ps
module ncur_nand_model #(
  parameter int POR_NS  = 4000,
  parameter int BUSY_NS = 2000
) (
  input  wire logic        ce_n,
  input  wire logic        cle,
  input  wire logic        ale,
  input  wire logic        we_n,
  input  wire logic        output_strobe_n,
  input  wire logic        wp_n,
  input  wire logic [7:0]  io_out,
  input  wire logic        fail_set,
  input  wire logic        hint_set,
  input  wire logic [10:0] bad_blk,
  output logic      [7:0]  io_in,
  output logic             ready_busy_output,
  output int               nbytes
);
  logic [12:0] col = 13'h0000;
  logic [16:0] row = 17'h00000;
  logic [2:0]  acnt = 3'h0;
  logic        st = 1'b0;
  logic        prg = 1'b0;
  logic        fst = 1'b0;
  event        go;
  wire  [7:0]  stat = {wp_n, ready_busy_output, ready_busy_output, 1'b0, hint_set, 2'b00, fst};
  initial begin
    io_in = 8'h00;
    nbytes = 0;
    ready_busy_output = 1'b0;
    #(POR_NS);
    ready_busy_output = 1'b1;
  end
  always @(go) begin
    ready_busy_output = 1'b0;
    #(BUSY_NS);
    ready_busy_output = 1'b1;
  end
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      prg = io_out == 8'h80 || (prg && io_out == 8'h85);
      case (io_out)
        8'hff: begin
          st = 1'b0;
          fst = 1'b0;
          ->go;
        end
        8'h70: st = 1'b1;
        8'h00: begin
          st = 1'b0;
          acnt = 3'h0;
        end
        8'h80: begin
          acnt = 3'h0;
          nbytes = 0;
        end
        8'h60: acnt = 3'h2;
        8'h30, 8'h10, 8'hd0: begin
          fst = fail_set || (io_out != 8'h30 && !wp_n);
          ->go;
        end
        default: ;
      endcase
    end else if (!ce_n && ale) begin
      case (acnt)
        3'h0: col[7:0] = io_out;
        3'h1: col[12:8] = io_out[4:0];
        3'h2: row[7:0] = io_out;
        3'h3: row[15:8] = io_out;
        3'h4: row[16] = io_out[0];
        default: ;
      endcase
      if (acnt < 3'h5) acnt++;
    end else if (!ce_n && prg) begin
      nbytes++;
      col++;
    end
  end
  always @(negedge output_strobe_n) begin
    io_in = st ? stat : ((col == 13'h1000 && row[16:6] == bad_blk) ? 8'h00 : col[7:0] ^ 8'h5a);
    if (!st) col++;
  end
  // Released bus must not keep the last byte
  always @(posedge output_strobe_n) io_in = ~io_in;
endmodule // ncur_nand_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  clk_en = 1'b1;
  logic                  cmd_valid = 1'b0;
  ncur_pkg::ncur_op_type cmd_op = ncur_pkg::NCUR_RESET;
  logic [10:0]           cmd_block = 11'h000;
  logic [5:0]            cmd_page = 6'h00;
  logic [2:0]            cmd_sector = 3'h0;
  logic [3:0]            cmd_nsect = 4'h1;
  logic                  protect = 1'b0;
  logic [7:0]            wr_data = 8'h00;
  logic                  wr_valid = 1'b0;
  logic                  fail_set = 1'b0;
  logic                  hint_set = 1'b0;
  logic [10:0]           bad_blk = 11'h7ff;
  logic [7:0]            rd_data, done_status, io_out, io_in;
  logic                  cmd_ready, wr_ready, rd_valid, done, refused, rewrite_hint, block_bad;
  logic                  init_done, ce_n, cle, ale, we_n, output_strobe_n, wp_n, io_oe;
  logic                  ready_busy_output;
  int                    nbytes, nrd, n_fail = 0, checks_done = 0, nbusy = 0;
  ncur_host uut (.*);
  ncur_nand_model nand_model (.*);
  always #20 ref_clk = ~ref_clk;
  always @(negedge ready_busy_output) nbusy++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [7:0] pat(input int c, input logic [10:0] b);
    return (c == 4096 && b == bad_blk) ? 8'h00 : 8'(c) ^ 8'h5a;
  endfunction
  task automatic run(input logic [2:0] op, input logic [10:0] b, input logic [5:0] p,
                     input logic [2:0] s, input logic [3:0] n);
    int i;
    int c;
    int k;
    i = 0;
    k = 0;
    c = (op == 3'h5) ? 4096 : s * 528;
    nrd = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= ncur_pkg::ncur_op_type'(op);
    cmd_block <= b;
    cmd_page <= p;
    cmd_sector <= s;
    cmd_nsect <= n;
    wr_data <= 8'h00;
    wr_valid <= op == 3'h3;
    do begin
      @(posedge ref_clk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 5000);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && i < 30000) begin
      @(posedge ref_clk);
      i++;
      if (wr_ready === 1'b1) begin
        k++;
        wr_data <= 8'(k);
      end
      if (rd_valid === 1'b1) begin
        chk(rd_data, pat(c, b));
        c++;
        nrd++;
      end
    end
    wr_valid <= 1'b0;
    if (done !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t request hung", $time);
      test_done();
    end
  endtask
  task automatic t_init();
    for (int i = 0; i < 5000 && init_done !== 1'b1; i++) @(posedge ref_clk);
    chk(init_done, 1'b1);
    chk(ready_busy_output, 1'b1);
    if (init_done !== 1'b1) test_done();
    $display("end init");
  endtask
  task automatic t_reset();
    int b0;
    b0 = nbusy;
    clk_en <= 1'b0;
    protect <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(wp_n, 1'b1);
    clk_en <= 1'b1;
    protect <= 1'b0;
    run(3'h0, 11'h000, 6'h00, 3'h0, 4'h1);
    run(3'h0, 11'h000, 6'h00, 3'h0, 4'h1);
    chk(8'(nbusy - b0), 8'h02);
    chk(refused, 1'b0);
    $display("end reset");
  endtask
  task automatic t_status();
    run(3'h1, 11'h000, 6'h00, 3'h0, 4'h1);
    chk(done_status, 8'he0);
    protect <= 1'b1;
    run(3'h1, 11'h000, 6'h00, 3'h0, 4'h1);
    chk(wp_n, 1'b0);
    chk(done_status, 8'h60);
    protect <= 1'b0;
    $display("end status");
  endtask
  task automatic t_prog();
    for (int j = 0; j < 5; j++) begin
      run(3'h3, 11'h001, 6'h00, 3'h0, 4'h1);
      chk(refused, j == 4);
    end
    chk(nbytes == 528, 1'b1);
    run(3'h3, 11'h001, 6'h02, 3'h0, 4'h1);
    chk(refused, 1'b0);
    run(3'h3, 11'h001, 6'h01, 3'h0, 4'h1);
    chk(refused, 1'b1);
    $display("end prog");
  endtask
  task automatic t_sect();
    run(3'h3, 11'h002, 6'h00, 3'h7, 4'h2);
    chk(refused, 1'b1);
    run(3'h3, 11'h002, 6'h00, 3'h0, 4'h0);
    chk(refused, 1'b1);
    run(3'h3, 11'h002, 6'h00, 3'h6, 4'h2);
    chk(refused, 1'b0);
    chk(nbytes == 1056, 1'b1);
    $display("end sect");
  endtask
  task automatic t_read();
    run(3'h2, 11'h001, 6'h00, 3'h1, 4'h1);
    chk(nrd == 528, 1'b1);
    chk(refused, 1'b0);
    $display("end read");
  endtask
  task automatic t_fail();
    fail_set <= 1'b1;
    run(3'h3, 11'h003, 6'h00, 3'h0, 4'h1);
    chk(block_bad, 1'b1);
    chk(done_status[0], 1'b1);
    fail_set <= 1'b0;
    run(3'h4, 11'h003, 6'h00, 3'h0, 4'h1);
    chk(refused, 1'b1);
    run(3'h3, 11'h003, 6'h01, 3'h0, 4'h1);
    chk(refused, 1'b1);
    run(3'h4, 11'h001, 6'h00, 3'h0, 4'h1);
    chk(block_bad, 1'b0);
    run(3'h3, 11'h001, 6'h00, 3'h0, 4'h1);
    chk(refused, 1'b0);
    $display("end fail");
  endtask
  task automatic t_check();
    bad_blk <= 11'h005;
    fail_set <= 1'b1;
    run(3'h5, 11'h005, 6'h00, 3'h0, 4'h1);
    chk(block_bad, 1'b1);
    hint_set <= 1'b1;
    run(3'h5, 11'h006, 6'h00, 3'h0, 4'h1);
    chk(block_bad, 1'b0);
    chk(rewrite_hint, 1'b1);
    fail_set <= 1'b0;
    hint_set <= 1'b0;
    run(3'h2, 11'h005, 6'h00, 3'h0, 4'h1);
    chk(refused, 1'b1);
    $display("end check");
  endtask
  task automatic t_refuse();
    for (int j = 6; j < 8; j++) begin
      run(3'(j), 11'h000, 6'h00, 3'h0, 4'h1);
      chk(refused, 1'b1);
    end
    $display("end refuse");
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_init();
    t_reset();
    t_status();
    t_prog();
    t_sect();
    t_read();
    t_fail();
    t_check();
    t_refuse();
    test_done();
  end
endmodule // testbench
